// ---- hdl/upper_timer.sv ----
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module upper_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fs_tick,
    input wire logic counter_pin,
    input wire logic cascade_overflow,
    input wire logic divider_tap_select,
    input wire logic slow_mode,
    output logic timer_match_interrupt,
    output logic irq,
    output logic timer_out,
    output logic upper_overflow
);
    upper_timer_pkg::bus_req_t req;
    upper_timer_pkg::control_t ctrl_q;
    logic [7:0] period_q;
    logic [7:0] pulse_q;
    logic [7:0] count_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [upper_timer_pkg::PRESCALE_WIDTH-1:0] fc_taps;
    logic fs8_tick;
    logic pin_rise;
    logic tick;
    logic match;
    logic pwm_hit;
    logic wrap;
    logic start;
    logic running;
    logic [1:0] events;
    logic [1:0] clr;
    logic [7:0] ctrl_w;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign running = ctrl_q.run;

    upper_timer_prescaler #(
        .WIDTH(upper_timer_pkg::PRESCALE_WIDTH)
    ) u_prescaler (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .fs_tick(fs_tick),
        .fc_taps(fc_taps),
        .fs8_tick(fs8_tick)
    );

    upper_timer_pin_sync u_pin (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin(counter_pin),
        .rise(pin_rise)
    );

    // =========================================================
    // Count source selection.
    always_comb
    begin
        tick = 1'b0;
        if (ctrl_q.mode[2])
            tick = cascade_overflow; // RULE_05
        else
        begin
            unique case (ctrl_q.clk_sel) // RULE_02
                3'h0: tick = (divider_tap_select || slow_mode) ? fs8_tick
                                                               : fc_taps[upper_timer_pkg::TAP_11-1];
                3'h1: tick = !slow_mode && fc_taps[upper_timer_pkg::TAP_7-1];
                3'h2: tick = !slow_mode && fc_taps[upper_timer_pkg::TAP_5-1];
                3'h3: tick = !slow_mode && fc_taps[upper_timer_pkg::TAP_3-1];
                3'h4: tick = fs_tick;
                3'h5: tick = !slow_mode && fc_taps[upper_timer_pkg::TAP_1-1];
                3'h6: tick = !slow_mode;
                3'h7: tick = pin_rise;
            endcase
        end
    end

    // =========================================================
    // Register writes.
    // A write with the run bit going 0 to 1 takes every field at once.
    assign ctrl_w = req.wdata;
    assign start = req.wr && req.addr == {1'b0, upper_timer_pkg::ADDR_CONTROL}
                   && ctrl_w[upper_timer_pkg::CTRL_RUN_POS] && !running;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ctrl_q <= upper_timer_pkg::CONTROL_RESET;
        else if (req.wr && req.addr == {1'b0, upper_timer_pkg::ADDR_CONTROL}) // RULE_01
            ctrl_q <= ctrl_w; // RULE_09
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            period_q <= upper_timer_pkg::PERIOD_RESET;
            pulse_q <= upper_timer_pkg::PULSE_RESET;
        end
        else if (req.wr)
        begin
            if (req.addr == {1'b0, upper_timer_pkg::ADDR_PERIOD})
                period_q <= req.wdata; // RULE_01
            if (req.addr == {1'b0, upper_timer_pkg::ADDR_PULSE_WIDTH})
                pulse_q <= req.wdata; // RULE_01
        end
    end

    // =========================================================
    // Up-counter.
    assign match = running && tick && (count_q == period_q - 8'h01 || period_q == 8'h00);
    assign wrap = running && tick && (count_q == 8'hff);
    assign pwm_hit = running && tick && (count_q == pulse_q - 8'h01);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !running)
            count_q <= 8'h00; // RULE_03
        else if (tick)
        begin
            unique case (ctrl_q.mode) // RULE_04 RULE_13
                upper_timer_pkg::MODE_PWM8,
                upper_timer_pkg::MODE_PWM16:
                    count_q <= count_q + 8'h01;
                upper_timer_pkg::MODE_RESERVED:
                    count_q <= count_q;
                default:
                    count_q <= match ? 8'h00 : count_q + 8'h01; // RULE_12
            endcase
        end
    end

    // =========================================================
    // Output flop: preset at start, toggled per mode afterwards.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            timer_out <= 1'b0;
        else if (start)
            timer_out <= ctrl_w[upper_timer_pkg::CTRL_FF_POS]; // RULE_14
        else if (running)
        begin
            unique case (ctrl_q.mode)
                upper_timer_pkg::MODE_DIVIDER8:
                    if (match)
                        timer_out <= !timer_out;
                upper_timer_pkg::MODE_PWM8,
                upper_timer_pkg::MODE_PWM16:
                    if (pwm_hit || wrap)
                        timer_out <= !timer_out;
                upper_timer_pkg::MODE_PPG16:
                    if (pwm_hit || match)
                        timer_out <= !timer_out;
                default:
                    timer_out <= timer_out;
            endcase
        end
    end

    // =========================================================
    // Events and interrupts; a set in the clearing cycle wins.
    always_comb
    begin
        events = 2'h0;
        if (ctrl_q.mode == upper_timer_pkg::MODE_PWM8 || ctrl_q.mode == upper_timer_pkg::MODE_PWM16)
            events[upper_timer_pkg::IRQ_MATCH_BIT] = wrap;
        else if (ctrl_q.mode != upper_timer_pkg::MODE_RESERVED)
            events[upper_timer_pkg::IRQ_MATCH_BIT] = match; // RULE_12
        events[upper_timer_pkg::IRQ_OVF_BIT] = wrap;
    end

    assign clr = (req.wr && req.addr == {1'b0, upper_timer_pkg::ADDR_IRQ_STATUS})
                 ? req.wdata[1:0] : 2'h0;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            status_q <= upper_timer_pkg::IRQ_RESET;
        else
            status_q <= (status_q & ~clr) | events;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            mask_q <= upper_timer_pkg::IRQ_RESET;
        else if (req.wr && req.addr == upper_timer_pkg::ADDR_IRQ_MASK)
            mask_q <= req.wdata[1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            irq <= 1'b0;
            timer_match_interrupt <= 1'b0;
            upper_overflow <= 1'b0;
        end
        else
        begin
            irq <= |(((status_q & ~clr) | events) & mask_q);
            timer_match_interrupt <= events[upper_timer_pkg::IRQ_MATCH_BIT];
            upper_overflow <= wrap;
        end
    end

    // =========================================================
    // Read data, one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (req.rd)
        begin
            unique case (req.addr)
                {1'b0, upper_timer_pkg::ADDR_CONTROL}: reg_rdata <= ctrl_q;
                {1'b0, upper_timer_pkg::ADDR_PERIOD}: reg_rdata <= period_q;
                {1'b0, upper_timer_pkg::ADDR_PULSE_WIDTH}: reg_rdata <= pulse_q;
                {1'b0, upper_timer_pkg::ADDR_IRQ_STATUS}: reg_rdata <= {6'h00, status_q};
                upper_timer_pkg::ADDR_IRQ_MASK: reg_rdata <= {6'h00, mask_q};
                upper_timer_pkg::ADDR_MISC: reg_rdata <= count_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end
endmodule

// ---- hdl/upper_timer_pin_sync.sv ----
`timescale 1ns/100ps
module upper_timer_pin_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pin,
    output logic rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // =========================================================
    // Three stages; the level moves only when stages two and three agree.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                level_q <= s3_q;
        end
    end

    assign rise = (s2_q == s3_q) && s3_q && !level_q;
endmodule

// ---- hdl/upper_timer_pkg.sv ----
// Behaviour
// [RULE_01] One control and two eight-bit compare registers.
// [RULE_02] Clock select picks prescaler tap, fs or pin.
// [RULE_03] Run bit zero stops and clears counter.
// [RULE_04] Mode select offers three 8-bit, four 16-bit modes.
// [RULE_05] Upper 16-bit modes count cascade overflow only.
// [RULE_06] Software sets lower mode to 011 for 16-bit.
// [RULE_07] Slow mode fc only for warm-up.
// [RULE_08] No control field changes while running or stopping.
// [RULE_09] Starting write may program all control fields.
// [RULE_10] No period change while running.
// [RULE_11] Pulse width changes while running only in PWM.
// [RULE_12] Timer match raises interrupt, clears, keeps counting.
// [RULE_13] Mode codes fixed as listed, 011 reserved.
// [RULE_14] Preset bit loads output flop at start.
package upper_timer_pkg;

    // =========================================================
    // Register map
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_PERIOD = 2'h1;
    localparam logic [1:0] ADDR_PULSE_WIDTH = 2'h2;
    localparam logic [1:0] ADDR_IRQ_STATUS = 2'h3;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
    localparam logic [2:0] ADDR_MISC = 3'h5;

    // =========================================================
    // Control fields and reset values
    localparam int CTRL_FF_POS = 7;
    localparam int CTRL_CLK_POS = 4;
    localparam int CTRL_RUN_POS = 3;
    localparam int CTRL_MODE_POS = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] PULSE_RESET = 8'hff;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;

    // =========================================================
    // Prescaler taps, as powers of two of fc; FS_TAP_3 as a power of two of fs
    localparam int TAP_11 = 11;
    localparam int TAP_7 = 7;
    localparam int TAP_5 = 5;
    localparam int TAP_3 = 3;
    localparam int TAP_1 = 1;
    localparam int FS_TAP_3 = 3;
    localparam int PRESCALE_WIDTH = 11;

    typedef enum logic [2:0] {
        MODE_TIMER8 = 3'h0,
        MODE_DIVIDER8 = 3'h1,
        MODE_PWM8 = 3'h2,
        MODE_RESERVED = 3'h3,
        MODE_TIMER16 = 3'h4,
        MODE_WARMUP = 3'h5,
        MODE_PWM16 = 3'h6,
        MODE_PPG16 = 3'h7
    } mode_t;

    typedef struct packed {
        logic ff_preset;
        logic [2:0] clk_sel;
        logic run;
        logic [2:0] mode;
    } control_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ---- hdl/upper_timer_prescaler.sv ----
`timescale 1ns/100ps
module upper_timer_prescaler #(
    parameter int WIDTH = upper_timer_pkg::PRESCALE_WIDTH
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic fs_tick,
    output logic [WIDTH-1:0] fc_taps,
    output logic fs8_tick
);
    logic [WIDTH-1:0] cnt_q;
    logic [2:0] fs_cnt_q;

    if (WIDTH < upper_timer_pkg::TAP_11)
    begin : g_width_check
        $error("prescaler too narrow");
    end

    // =========================================================
    // Free-running fc divider; tap bit k pulses once every 2^(k+1) cycles.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    genvar k;
    generate
        for (k = 0; k < WIDTH; k++)
        begin : g_tap
            assign fc_taps[k] = &cnt_q[k:0];
        end
    endgenerate

    // =========================================================
    // fs divided by eight.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            fs_cnt_q <= 3'h0;
        else if (fs_tick)
            fs_cnt_q <= fs_cnt_q + 3'h1;
    end

    assign fs8_tick = fs_tick && (&fs_cnt_q);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fs_tick = 1'b0;
    logic counter_pin = 1'b0;
    logic cascade_overflow = 1'b0;
    logic divider_tap_select = 1'b0;
    logic slow_mode = 1'b0;
    logic [7:0] reg_rdata;
    logic timer_match_interrupt, irq, timer_out, upper_overflow;
    logic rd_q = 1'b0;
    logic [31:0] lfsr = 32'hcd46_883e;
    logic [7:0] exp_q[$];
    int failures = 0;
    int compares = 0;
    upper_timer upper_timer_i (.*);
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end
    // ========
    // Bus tasks and checks
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes stay up between back-to-back calls so no edge sees a glitch.
    task automatic wr(logic [2:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic idle(int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    // Selector 0 waits for a match pulse, 1 for an overflow pulse, 2 for a high output flop.
    task automatic wait_match(int sel, output int n);
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 600)
        begin
            @(posedge sys_clk);
            n++;
            seen = (sel == 0) ? timer_match_interrupt === 1'b1
                 : (sel == 1) ? upper_overflow === 1'b1 : timer_out === 1'b1;
        end
        if (!seen)
        begin
            failures++;
            complete_run();
        end
    endtask
    always @(posedge sys_clk)
    begin
        if (rd_q)
            check(reg_rdata, exp_q.pop_front());
        rd_q <= reg_rd;
    end
    // ========
    // Scenarios
    initial
    begin
        int n;
        logic [7:0] p, pw;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
            rd(3'(i), (i == 1 || i == 2) ? 8'hff : 8'h00);
        lfsr = lfsr_next(lfsr);
        p = 8'(2 + lfsr[7:0] % 7);
        pw = 8'(2 + lfsr[15:8] % 253);
        wr(3'h1, p);
        wr(3'h2, pw);
        rd(3'h1, p);
        rd(3'h2, pw);
        for (int m = 0; m < 8; m++)
        begin
            wr(3'h0, {5'h0d, 3'(m)});
            rd(3'h0, {5'h0d, 3'(m)});
            wr(3'h0, {5'h0c, 3'(m)});
            idle(1);
            rd(3'h5, 8'h00);
        end
        wr(3'h0, 8'h68);
        idle(1);
        wait_match(0, n);
        wait_match(0, n);
        check(8'(n), p);
        wr(3'h4, 8'h01);
        idle(2);
        check({7'h00, irq}, 8'h01);
        wr(3'h0, 8'h60);
        idle(2);
        rd(3'h3, 8'h01);
        wr(3'h3, 8'h03);
        idle(2);
        rd(3'h5, 8'h00);
        rd(3'h3, 8'h00);
        idle(1);
        check({7'h00, irq}, 8'h00);
        wr(3'h0, 8'he8);
        idle(2);
        check({7'h00, timer_out}, 8'h01);
        wr(3'h0, 8'he0);
        wr(3'h0, 8'h68);
        idle(2);
        check({7'h00, timer_out}, 8'h00);
        wr(3'h0, 8'h60);
        wr(3'h0, 8'h6c);
        idle(6);
        rd(3'h5, 8'h00);
        idle(1);
        cascade_overflow <= 1'b1;
        idle(1);
        cascade_overflow <= 1'b0;
        idle(int'(lfsr[18:16]) + 1);
        rd(3'h5, 8'h01);
        wr(3'h0, 8'h64);
        slow_mode <= 1'b1;
        wr(3'h0, 8'h58);
        idle(6);
        rd(3'h5, 8'h00);
        wr(3'h0, 8'h50);
        wr(3'h0, 8'h48);
        idle(3);
        fs_tick <= 1'b1;
        idle(1);
        fs_tick <= 1'b0;
        idle(2);
        rd(3'h5, 8'h01);
        wr(3'h0, 8'h40);
        wr(3'h0, 8'h78);
        idle(3);
        counter_pin <= 1'b1;
        idle(8);
        rd(3'h5, 8'h01);
        wr(3'h0, 8'h70);
        slow_mode <= 1'b0;
        divider_tap_select <= 1'b1;
        wr(3'h0, 8'h08);
        // Any eight low-clock pulses hold exactly one divided tick.
        repeat (8)
        begin
            fs_tick <= 1'b1;
            idle(1);
            fs_tick <= 1'b0;
            idle(1);
        end
        rd(3'h5, 8'h01);
        wr(3'h0, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h02);
        wr(3'h0, 8'h6a);
        wait_match(1, n);
        wait_match(2, n);
        check(8'(n), pw);
        check({7'h00, irq}, 8'h01);
        rd(3'h3, 8'h03);
        wr(3'h0, 8'h62);
        idle(2);
        complete_run();
    end
endmodule

// ---- test/upper_timer_props.sv ----
`timescale 1ns/100ps
module upper_timer_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_match_interrupt,
    input wire logic irq,
    input wire logic timer_out,
    input wire logic upper_overflow
);
    // ========
    // Register mirror
    logic [7:0] ctrl_q, per_q, pw_q, mask_q;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q <= upper_timer_pkg::CONTROL_RESET;
            per_q <= upper_timer_pkg::PERIOD_RESET;
            pw_q <= upper_timer_pkg::PULSE_RESET;
            mask_q <= 8'h00;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                3'h0: ctrl_q <= reg_wdata;
                3'h1: per_q <= reg_wdata;
                3'h2: pw_q <= reg_wdata;
                3'h4: mask_q <= reg_wdata;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // ========
    // Checks
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_unmapped_read: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_period_read: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata == $past(per_q))
        else $error("period read back wrong");
    chk_pulse_read: assert property (reg_rd && reg_addr == 3'h2 |=> reg_rdata == $past(pw_q))
        else $error("pulse width read back wrong");
    chk_ctrl_read: assert property (reg_rd && reg_addr == 3'h0 |=> reg_rdata == $past(ctrl_q))
        else $error("control read back wrong");
    chk_mask_gates: assert property (mask_q[1:0] == 2'h0 && $past(mask_q[1:0]) == 2'h0 |-> !irq)
        else $error("irq raised while masked");
    chk_stop_quiet: assert property (!ctrl_q[3] && !$past(ctrl_q[3]) && !$past(ctrl_q[3], 2)
        |-> !timer_match_interrupt && !upper_overflow)
        else $error("event while stopped");
    chk_preset_start: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[3] && !ctrl_q[3]
        && reg_wdata[2:0] == 3'h0 |=> ##1 timer_out == $past(reg_wdata[7], 2))
        else $error("output flop not preset at start");
    chk_match_irq: assert property (timer_match_interrupt && mask_q[0] && $past(mask_q[0])
        |-> ##[0:1] irq)
        else $error("match did not raise irq");
    cov_match: cover property (timer_match_interrupt);
    cov_irq: cover property (irq);
    cov_start: cover property (reg_wr && reg_addr == 3'h0 && reg_wdata[3]);
endmodule
bind upper_timer upper_timer_props upper_timer_props_i (.*);
